/* File: scp_pkg.sv */
/*
 Package for the serial command port: bit counts, FIFO depth and the
 edge-mode encoding used by the port, which passes width and depth to its byte FIFO.
 Assumes a single 100 MHz system clock.
*/
package scp_pkg;
	localparam int         SCP_BYTE_BITS   = 8;
	localparam int         SCP_FIFO_DEPTH  = 16;
	localparam logic [2:0] SCP_CNT_LAST    = 3'h7;
	localparam logic [2:0] SCP_CNT_RESET   = 3'h0;
	localparam logic [7:0] SCP_BYTE_RESET  = 8'h00;
	localparam logic       SCP_MODE_RISE   = 1'b1;
	localparam logic       SCP_MODE_RESET  = 1'b1;
	typedef enum logic [1:0] {
		SCP_IDLE = 2'b01,
		SCP_XFER = 2'b10
	} scp_state_t;
endpackage

/* File: scp_fifo.sv */
/*
 Synchronous FIFO with valid/ready on both sides; width and depth are
 parameters. Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module scp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             sys_rst_in,
	// Fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// Drain side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	// Handshake terms, full and empty from the occupancy count
	assign in_ready_out  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_reg != '0);
	assign out_data_out  = mem_reg[rd_reg];
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	// Pointer and count next values
	always_comb begin
		wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	// Storage needs no reset; only pointers and count do
	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data_in;
		end
		if (sys_rst_in) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule

/* File: scp_port.sv */
/*
 Serial command port: host select, shift clock and data-in are sampled by
 the 100 MHz system clock; completed bytes go through a 16-word FIFO to the
 command decoder, and status bytes are shifted back on data-out.
 Assumes the shift clock is at least four system cycles per half period.
*/
`timescale 1ns/1ns
module scp_port (
	// Clock and reset
	input  wire logic                              ref_clk_in,
	input  wire logic                              sys_rst_in,
	// Host pins
	input  wire logic                              host_select_n_in,
	input  wire logic                              host_sck_in,
	input  wire logic                              host_sdi_in,
	output logic                                   host_sdo_out,
	output logic                                   host_sdo_oe_out,
	// Command bytes to the decoder
	output logic                                   cmd_valid_out,
	output logic [scp_pkg::SCP_BYTE_BITS-1:0]      cmd_data_out,
	input  wire logic                              cmd_ready_in,
	// Status byte from the device
	input  wire logic [scp_pkg::SCP_BYTE_BITS-1:0] status_in,
	// Lost byte pulse when the FIFO was full
	output logic                                   overrun_out
);
	import scp_pkg::*;

	logic [2:0] sel_sync_reg, sck_sync_reg, sdi_sync_reg;
	logic       sel_n, sck, sck_prev, sdi;
	logic       rise, fall, sample_edge, shift_edge;
	scp_state_t state_reg, state_next;
	logic       mode_reg, mode_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] so_reg, so_next;
	logic       push_reg, push_next;
	logic [7:0] byte_reg, byte_next;
	logic       fifo_ready;
	logic [1:0] sel_live_reg, sel_live_next;
	logic       sel_seen_reg, sel_seen_next;

	// Two-flop synchronisers; the third stage is only for edge finding
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			sel_sync_reg <= 3'h7;
			sck_sync_reg <= 3'h0;
			sdi_sync_reg <= 3'h0;
		end else begin
			sel_sync_reg <= {sel_sync_reg[1:0], host_select_n_in};
			sck_sync_reg <= {sck_sync_reg[1:0], host_sck_in};
			sdi_sync_reg <= {sdi_sync_reg[1:0], host_sdi_in};
		end
	end
	assign sel_n    = sel_sync_reg[1];
	assign sck      = sck_sync_reg[1];
	assign sck_prev = sck_sync_reg[2];
	assign sdi      = sdi_sync_reg[1];
	assign rise     = sck && !sck_prev;
	assign fall     = !sck && sck_prev;
	assign sample_edge = (mode_reg == SCP_MODE_RISE) ? rise : fall;
	assign shift_edge  = (mode_reg == SCP_MODE_RISE) ? fall : rise;

	// Port sequencer next state
	always_comb begin
		state_next = state_reg;
		mode_next  = mode_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		so_next    = so_reg;
		push_next  = 1'b0;
		byte_next  = byte_reg;
		// Select counts as seen high only once the synchroniser holds pin values
		sel_live_next = {sel_live_reg[0], 1'b1};
		sel_seen_next = sel_seen_reg || (sel_live_reg[1] && sel_n);
		case (state_reg)
			SCP_IDLE: begin
				so_next = status_in;
				if (!sel_n) begin
					state_next = SCP_XFER;
					// No real select fall since reset means select is tied low
					mode_next  = sel_seen_reg ? sck : SCP_MODE_RISE;
					cnt_next   = SCP_CNT_RESET;
					sh_next    = SCP_BYTE_RESET;
				end
			end
			SCP_XFER: begin
				if (sel_n) begin
					state_next = SCP_IDLE;
					cnt_next   = SCP_CNT_RESET;
					sh_next    = SCP_BYTE_RESET;
				end else begin
					if (sample_edge) begin
						sh_next  = {sh_reg[6:0], sdi};
						cnt_next = 3'(cnt_reg + 1'b1);
						if (cnt_reg == SCP_CNT_LAST) begin
							byte_next = {sh_reg[6:0], sdi};
							push_next = 1'b1;
						end
					end
					// First shift clock edge of a byte loads a fresh status copy
					if (shift_edge) begin
						so_next = (cnt_reg == SCP_CNT_RESET) ? status_in
							: {so_reg[6:0], 1'b0};
					end
				end
			end
			default: begin
				state_next = SCP_IDLE;
			end
		endcase
	end

	// Sequencer registers; reset mode is rising-edge sampling
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= SCP_IDLE;
			mode_reg  <= SCP_MODE_RESET;
			cnt_reg   <= SCP_CNT_RESET;
			sh_reg    <= SCP_BYTE_RESET;
			so_reg    <= SCP_BYTE_RESET;
			push_reg  <= 1'b0;
			byte_reg  <= SCP_BYTE_RESET;
			sel_live_reg <= 2'h0;
			sel_seen_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			mode_reg  <= mode_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			so_reg    <= so_next;
			push_reg  <= push_next;
			byte_reg  <= byte_next;
			sel_live_reg <= sel_live_next;
			sel_seen_reg <= sel_seen_next;
		end
	end

	// Output is released whenever select is seen high
	assign host_sdo_out    = so_reg[7];
	assign host_sdo_oe_out = (state_reg == SCP_XFER) && !sel_n;
	// A byte arriving on a full FIFO is dropped; the host cannot be stalled
	assign overrun_out     = push_reg && !fifo_ready;

	// Byte FIFO toward the command decoder
	scp_fifo #(
		.WIDTH (SCP_BYTE_BITS),
		.DEPTH (SCP_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in    (ref_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (push_reg),
		.in_data_in    (byte_reg),
		.in_ready_out  (fifo_ready),
		.out_valid_out (cmd_valid_out),
		.out_data_out  (cmd_data_out),
		.out_ready_in  (cmd_ready_in)
	);

	// Checks
	property p_mode_pick;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_reg == SCP_IDLE && !sel_n)
			|=> (mode_reg == ($past(sel_seen_reg) ? $past(sck) : SCP_MODE_RISE));
	endproperty
	a_mode_pick: assert property (p_mode_pick) else $error("edge mode not taken");
	property p_oe_off;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		sel_n |-> !host_sdo_oe_out;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("sdo driven while idle");
	property p_clear;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_reg == SCP_XFER && sel_n) |=> (cnt_reg == 3'h0 && sh_reg == 8'h00);
	endproperty
	a_clear: assert property (p_clear) else $error("no clear on deselect");
	property p_push;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_reg == SCP_XFER && !sel_n && sample_edge && cnt_reg == 3'h7)
			|=> push_reg && byte_reg == {$past(sh_reg[6:0]), $past(sdi)};
	endproperty
	a_push: assert property (p_push) else $error("byte not latched");
	property p_shift_in;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_reg == SCP_XFER && !sel_n && sample_edge)
			|=> sh_reg[0] == $past(sdi) && sh_reg[7:1] == $past(sh_reg[6:0]);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("msb-first shift wrong");
	property p_rise_mode;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_reg == SCP_XFER && !sel_n && mode_reg && fall) |=> $stable(cnt_reg);
	endproperty
	a_rise_mode: assert property (p_rise_mode) else $error("sampled on wrong edge");
	property p_fall_mode;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_reg == SCP_XFER && !sel_n && !mode_reg && rise) |=> $stable(cnt_reg);
	endproperty
	a_fall_mode: assert property (p_fall_mode) else $error("sampled on wrong edge");
	property p_sdo_step;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_reg == SCP_XFER && !sel_n && shift_edge && cnt_reg != 3'h0)
			|=> so_reg[7] == $past(so_reg[6]);
	endproperty
	a_sdo_step: assert property (p_sdo_step) else $error("status not shifted");
	property p_strobe;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		push_reg |=> !push_reg;
	endproperty
	a_strobe: assert property (p_strobe) else $error("push wider than a cycle");
	property p_reset_mode;
		@(posedge ref_clk_in) $fell(sys_rst_in) |-> mode_reg == 1'b1;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("reset mode not rising");
	c_byte: cover property (@(posedge ref_clk_in) push_reg && fifo_ready);
	c_fall_xfer: cover property (@(posedge ref_clk_in) state_reg == SCP_XFER && !mode_reg);
	c_overrun: cover property (@(posedge ref_clk_in) overrun_out);
endmodule

/* File: scp_host_model.sv */
/*
 Host controller model for the serial command port: drives select, shift
 clock and data-in, and captures data-out. Assumes a 100 MHz system clock
 and a 160 ns shift clock (8 system cycles per half period).
*/
`timescale 1ns/1ns
module scp_host_model (
	// Clock
	input  wire logic ref_clk_in,
	// Serial pins
	output logic      sel_n_out,
	output logic      sck_out,
	output logic      sdi_out,
	input  wire logic sdo_in
);
	// Idle pins at time zero
	initial begin
		sel_n_out = 1'b1;
		sck_out   = 1'b1;
		sdi_out   = 1'b0;
	end

	// Park the pins between frames
	task automatic park(input logic sel_n, input logic sck);
		@(posedge ref_clk_in);
		sel_n_out <= sel_n;
		sck_out   <= sck;
		repeat (8) @(posedge ref_clk_in);
	endtask

	// One frame of n bits; keep leaves select untouched
	task automatic xfer(input logic idle, input logic [15:0] tx, input int n,
		input logic keep, output logic [15:0] rx);
		rx = 16'h0000;
		if (!keep) begin
			park(1'b1, idle);
			sel_n_out <= 1'b0;
			repeat (8) @(posedge ref_clk_in);
		end
		// Data moves mid-phase so neither edge sees it change
		for (int i = n - 1; i >= 0; i--) begin
			sdi_out <= tx[i];
			repeat (4) @(posedge ref_clk_in);
			sck_out <= ~idle;
			repeat (8) @(posedge ref_clk_in);
			rx = {rx[14:0], sdo_in};
			sck_out <= idle;
			repeat (4) @(posedge ref_clk_in);
		end
		// Released data line shows the inverse of its last bit
		sdi_out <= ~tx[0];
		if (!keep) begin
			sel_n_out <= 1'b1;
		end
		repeat (8) @(posedge ref_clk_in);
	endtask
endmodule

/* File: serial_command_port_tb_top.sv */
/*
 Testbench for the serial command port: host model on the pins, bench as
 the command decoder. Assumes the port and its FIFO from the design files.
*/
`timescale 1ns/1ns
module serial_command_port_tb_top;
	import scp_pkg::*;
	logic        ref_clk, rst, sel_n, sck, sdi, sdo, sdo_oe, sdo_last, sdo_line;
	logic        cmd_valid, cmd_ready, overrun;
	logic [7:0]  cmd_data, status;
	logic [15:0] rx;
	int          err_total = 0;
	int          checks_done = 0;
	int          ovr_cnt = 0;

	// Released data-out floats away from its last value
	assign sdo_line = sdo_oe ? sdo : ~sdo_last;
	// Sampled on the falling edge, where design outputs have settled
	always @(negedge ref_clk) begin
		if (sdo_oe === 1'b1) sdo_last <= sdo;
		if (overrun === 1'b1) ovr_cnt++;
	end

	initial begin
		ref_clk  = 1'b0;
		sdo_last = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	scp_host_model host (.ref_clk_in(ref_clk), .sel_n_out(sel_n), .sck_out(sck),
		.sdi_out(sdi), .sdo_in(sdo_line));
	scp_port uut (.ref_clk_in(ref_clk), .sys_rst_in(rst), .host_select_n_in(sel_n),
		.host_sck_in(sck), .host_sdi_in(sdi), .host_sdo_out(sdo),
		.host_sdo_oe_out(sdo_oe), .cmd_valid_out(cmd_valid), .cmd_data_out(cmd_data),
		.cmd_ready_in(cmd_ready), .status_in(status), .overrun_out(overrun));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
			err_total++;
		end
	endtask

	// Wait for a byte under a bound, compare it, then pop it
	// Outputs are read on the falling edge; ready moves just after a rising edge
	task automatic pop(input logic [7:0] exp);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (cmd_valid !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		chk({15'h0000, cmd_valid}, 16'h0001, "command byte present");
		chk({8'h00, cmd_data}, {8'h00, exp}, "command byte");
		@(posedge ref_clk);
		cmd_ready <= 1'b1;
		@(posedge ref_clk);
		cmd_ready <= 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic t_modes();
		status <= 8'h3C;
		host.xfer(1'b1, 16'h00A5, 8, 1'b0, rx);
		chk(rx, 16'h003C, "status in rising mode");
		pop(8'hA5);
		status <= 8'hC3;
		host.xfer(1'b0, 16'h5A96, 16, 1'b0, rx);
		chk(rx, 16'hC3C3, "status over two bytes");
		pop(8'h5A);
		pop(8'h96);
	endtask

	// Partial byte must vanish when select rises
	task automatic t_abort();
		host.xfer(1'b1, 16'h001F, 5, 1'b0, rx);
		chk({15'h0000, sdo_oe}, 16'h0000, "data-out enable while deselected");
		host.xfer(1'b0, 16'h00E1, 8, 1'b0, rx);
		pop(8'hE1);
		chk({15'h0000, cmd_valid}, 16'h0000, "no stray byte");
	endtask

	// Fill past the FIFO depth with the decoder stalled, then drain
	task automatic t_fill();
		ovr_cnt = 0;
		for (int i = 0; i <= SCP_FIFO_DEPTH; i++) begin
			host.xfer(1'b1, 16'(i * 17), 8, 1'b0, rx);
		end
		chk(16'(ovr_cnt), 16'h0001, "overrun pulses");
		for (int i = 0; i < SCP_FIFO_DEPTH; i++) begin
			pop(8'(i * 17));
		end
		chk({15'h0000, cmd_valid}, 16'h0000, "FIFO drained");
	endtask

	// Select low through reset: only rising edges may sample
	task automatic t_hold_low();
		host.park(1'b0, 1'b0);
		rst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		host.xfer(1'b1, 16'h0081, 8, 1'b1, rx);
		pop(8'h81);
	endtask

	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		rst       = 1'b1;
		cmd_ready = 1'b0;
		status    = 8'h00;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		t_modes();
		t_abort();
		t_fill();
		t_hold_low();
		test_done();
	end

	// Watchdog well beyond the expected 35 us of traffic
	initial begin
		#400000;
		err_total++;
		test_done();
	end
endmodule
